// [logic/gt_pkg.sv]
// constants and carrier types shared by the guard timer
package gt_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int CNT_W = 24;

   // register byte offsets
   localparam logic [4:0] CTRL_OFS = 5'h00;
   localparam logic [4:0] RELOAD_OFS = 5'h04;
   localparam logic [4:0] FEED_OFS = 5'h08;
   localparam logic [4:0] COUNT_OFS = 5'h0c;
   localparam logic [4:0] STATUS_OFS = 5'h10;
   localparam logic [4:0] MASK_OFS = 5'h14;
   localparam logic [4:0] CLKSEL_OFS = 5'h18;
   localparam logic [4:0] RSTFLAG_OFS = 5'h1c;

   // field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_RSTMODE_BIT = 1;
   localparam int ST_TIMEOUT_BIT = 0;
   localparam int ST_BADFEED_BIT = 1;
   localparam int CLKSEL_EXT_BIT = 0;

   // reset values
   localparam logic [23:0] RELOAD_RST = 24'hffffff;
   localparam logic [23:0] COUNT_RST = 24'hffffff;
   localparam logic [1:0] MASK_RST = 2'h0;

   // feed sequence and counter floor
   localparam logic [7:0] FEED_FIRST = 8'haa;
   localparam logic [7:0] FEED_SECOND = 8'h55;
   localparam logic [23:0] MIN_LOAD = 24'h0000ff;

   // timing
   localparam int SYS_CLK_HZ = 40_000_000;
   localparam int DERIVED_TICK_HZ = 2_000_000;
   localparam int TICK_DIV = SYS_CLK_HZ / DERIVED_TICK_HZ;
   localparam logic [4:0] TICK_DIV_LAST = 5'(TICK_DIV - 1);
   localparam int PRESCALE = 4;
   localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE - 1);

   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [3:0] byteenable;
   } gt_av_req_t;

   typedef enum logic {FEED_IDLE, FEED_HALF} gt_feed_state_t;
endpackage

// [logic/gt_guard_timer.sv]
// guard timer: watchdog with Avalon-MM register slave
// Function
// (R1) reset system when reload misses the interval
// (R2) enable is set-only; cleared by reset/fire
// (R3) bad or incomplete feed triggers the response
// (R4) readable flag marks a watchdog-caused reset
// (R5) fixed divide-by-four prescaler before counter
// (R6) 24-bit counter decrements per tick, expires
// (R7) reload below 0xff loads 0xff instead
// (R8) interval 256*4 to 2^24*4 tick periods
// (R9) tick from derived 2 MHz or external
// (R10) mode picks system reset or interrupt
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module gt_guard_timer (
   input wire logic sys_clk, // 40 MHz clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic porRst_b, // power-on reset, clears reset flag only
   input wire gt_pkg::gt_av_req_t avReq, // avalon request group
   output logic [31:0] avReadData, // avalon readdata
   output logic avWaitRequest, // avalon waitrequest
   input wire logic extClk, // external tick clock pin
   output logic sysResetReq, // one-cycle system reset request
   output logic irq // level interrupt
);

   logic ack_reg;
   logic [31:0] readData_reg;
   logic enable_reg;
   logic resetMode_reg;
   logic clkSelExt_reg;
   logic [23:0] reload_reg;
   logic [23:0] count_reg;
   logic [1:0] status_reg;
   logic [1:0] mask_reg;
   logic rstFlag_reg;
   logic sysResetReq_reg;
   logic [4:0] divCnt_reg;
   logic [1:0] preCnt_reg;
   logic extSync1_reg;
   logic extSync2_reg;
   logic extPrev_reg;
   gt_pkg::gt_feed_state_t feedState_reg;

   logic wrAcc;
   logic rdAcc;
   logic [31:0] beMask;
   logic [31:0] wrMerge;
   logic [31:0] wrBits;
   logic intTick;
   logic extTick;
   logic srcTick;
   logic preTick;
   logic fire;
   logic feedOk;
   logic badFeed;
   logic event_;
   logic enableSet;
   logic [23:0] loadVal;
   logic [23:0] ticksSinceLoad_reg;
   logic [23:0] loadedVal_reg;

   // bus: one wait cycle, then the access completes
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avReq.read | avReq.write) & ~ack_reg;
      end
   end

   assign avWaitRequest = (avReq.read | avReq.write) & ~ack_reg;
   assign wrAcc = avReq.write & ack_reg;
   assign rdAcc = avReq.read & ~ack_reg;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         beMask[i*8 +: 8] = {8{avReq.byteenable[i]}};
      end
   end

   assign wrBits = avReq.writedata & beMask;

   always_comb begin
      unique case (avReq.address)
         gt_pkg::RELOAD_OFS: wrMerge = ({8'h00, reload_reg} & ~beMask) | wrBits;
         default: wrMerge = wrBits;
      endcase
   end

   // read data registered in the wait cycle; unmapped reads return zero
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         readData_reg <= 32'h00000000;
      end else if (rdAcc) begin
         unique case (avReq.address)
            gt_pkg::CTRL_OFS: readData_reg <= {30'h0, resetMode_reg, enable_reg};
            gt_pkg::RELOAD_OFS: readData_reg <= {8'h00, reload_reg};
            gt_pkg::COUNT_OFS: readData_reg <= {8'h00, count_reg};
            gt_pkg::STATUS_OFS: readData_reg <= {30'h0, status_reg};
            gt_pkg::MASK_OFS: readData_reg <= {30'h0, mask_reg};
            gt_pkg::CLKSEL_OFS: readData_reg <= {31'h0, clkSelExt_reg};
            gt_pkg::RSTFLAG_OFS: readData_reg <= {31'h0, rstFlag_reg}; // R4
            default: readData_reg <= 32'h00000000;
         endcase
      end
   end

   assign avReadData = readData_reg;

   // configuration written by software
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         resetMode_reg <= 1'b1;
         clkSelExt_reg <= 1'b0;
         reload_reg <= gt_pkg::RELOAD_RST;
         mask_reg <= gt_pkg::MASK_RST;
      end else if (wrAcc) begin
         if (avReq.address == gt_pkg::CTRL_OFS && avReq.byteenable[0]) begin
            resetMode_reg <= avReq.writedata[gt_pkg::CTRL_RSTMODE_BIT]; // R10
         end
         if (avReq.address == gt_pkg::RELOAD_OFS) begin
            reload_reg <= wrMerge[23:0];
         end
         if (avReq.address == gt_pkg::MASK_OFS && avReq.byteenable[0]) begin
            mask_reg <= avReq.writedata[1:0];
         end
         if (avReq.address == gt_pkg::CLKSEL_OFS && avReq.byteenable[0]) begin
            clkSelExt_reg <= avReq.writedata[gt_pkg::CLKSEL_EXT_BIT];
         end
      end
   end

   // tick sources: derived 2 MHz enable or synchronised external edge
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         divCnt_reg <= 5'h00;
      end else if (divCnt_reg == gt_pkg::TICK_DIV_LAST) begin
         divCnt_reg <= 5'h00;
      end else begin
         divCnt_reg <= divCnt_reg + 5'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         extSync1_reg <= 1'b0;
         extSync2_reg <= 1'b0;
         extPrev_reg <= 1'b0;
      end else begin
         extSync1_reg <= extClk;
         extSync2_reg <= extSync1_reg;
         extPrev_reg <= extSync2_reg;
      end
   end

   assign intTick = (divCnt_reg == gt_pkg::TICK_DIV_LAST);
   assign extTick = extSync2_reg & ~extPrev_reg;
   // external clock must stay below 20 MHz to be seen edge by edge
   assign srcTick = clkSelExt_reg ? extTick : intTick; // R9

   always_ff @(posedge sys_clk) begin
      if (!rst_b || !enable_reg) begin
         preCnt_reg <= 2'h0;
      end else if (srcTick) begin
         preCnt_reg <= preCnt_reg + 2'h1; // R5
      end
   end

   assign preTick = enable_reg & srcTick & (preCnt_reg == gt_pkg::PRESCALE_LAST); // R5

   // feed sequence checker
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         feedState_reg <= gt_pkg::FEED_IDLE;
      end else if (wrAcc) begin
         if (avReq.address == gt_pkg::FEED_OFS && feedState_reg == gt_pkg::FEED_IDLE
             && wrBits[7:0] == gt_pkg::FEED_FIRST) begin
            feedState_reg <= gt_pkg::FEED_HALF;
         end else begin
            feedState_reg <= gt_pkg::FEED_IDLE;
         end
      end
   end

   assign feedOk = wrAcc && avReq.address == gt_pkg::FEED_OFS
                   && feedState_reg == gt_pkg::FEED_HALF && wrBits[7:0] == gt_pkg::FEED_SECOND;
   // a wrong value, or any other register write between the two halves, is a bad feed
   assign badFeed = enable_reg && wrAcc && !feedOk
                    && ((avReq.address == gt_pkg::FEED_OFS && !(feedState_reg == gt_pkg::FEED_IDLE
                         && wrBits[7:0] == gt_pkg::FEED_FIRST))
                        || (avReq.address != gt_pkg::FEED_OFS && feedState_reg == gt_pkg::FEED_HALF)); // R3

   assign fire = preTick && count_reg == 24'h000000; // R1 R6
   assign event_ = fire | badFeed;
   assign enableSet = wrAcc && avReq.address == gt_pkg::CTRL_OFS && avReq.byteenable[0]
                      && avReq.writedata[gt_pkg::CTRL_EN_BIT];
   assign loadVal = (reload_reg < gt_pkg::MIN_LOAD) ? gt_pkg::MIN_LOAD : reload_reg; // R7

   // enable: software can only set it; the firing event drops it
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         enable_reg <= 1'b0;
      end else if (event_) begin
         enable_reg <= 1'b0; // R2
      end else if (enableSet) begin
         enable_reg <= 1'b1; // R2
      end
   end

   // counter: loaded on enable and good feed, counts down on prescaled ticks
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         count_reg <= gt_pkg::COUNT_RST;
      end else if ((enableSet && !enable_reg) || (feedOk && enable_reg) || event_) begin
         count_reg <= loadVal; // R7 R8
      end else if (preTick && count_reg != 24'h000000) begin
         count_reg <= count_reg - 24'h000001; // R6
      end
   end

   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         status_reg <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == gt_pkg::ST_TIMEOUT_BIT && fire) || (i == gt_pkg::ST_BADFEED_BIT && badFeed)) begin
               status_reg[i] <= 1'b1;
            end else if (wrAcc && avReq.address == gt_pkg::STATUS_OFS && wrBits[i]) begin
               status_reg[i] <= 1'b0;
            end
         end
      end
   end

   assign irq = |(status_reg & mask_reg);

   // reset request in reset mode; flag survives the system reset it causes
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sysResetReq_reg <= 1'b0;
      end else begin
         sysResetReq_reg <= event_ & resetMode_reg; // R1 R3 R10
      end
   end

   assign sysResetReq = sysResetReq_reg;

   always_ff @(posedge sys_clk) begin
      if (!porRst_b) begin
         rstFlag_reg <= 1'b0;
      end else if (rst_b && event_ && resetMode_reg) begin
         rstFlag_reg <= 1'b1; // R4
      end else if (rst_b && wrAcc && avReq.address == gt_pkg::RSTFLAG_OFS && wrBits[0]) begin
         rstFlag_reg <= 1'b0;
      end
   end

   // checker helper: prescaled ticks seen since the counter was last loaded
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ticksSinceLoad_reg <= 24'h000000;
         loadedVal_reg <= gt_pkg::COUNT_RST;
      end else if ((enableSet && !enable_reg) || (feedOk && enable_reg) || event_) begin
         ticksSinceLoad_reg <= 24'h000000;
         loadedVal_reg <= loadVal;
      end else if (preTick) begin
         ticksSinceLoad_reg <= ticksSinceLoad_reg + 24'h000001;
      end
   end

   // assertions
   chk_fire_resets: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
      fire && resetMode_reg |=> sysResetReq ##1 !sysResetReq)
      else $error("timeout in reset mode did not pulse reset request");
   chk_enable_sticky: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2
      enable_reg && !$past(event_) |-> $past(enable_reg) || $past(enableSet))
      else $error("enable rose without a software set");
   chk_enable_drop: assert property (@(posedge sys_clk) disable iff (!rst_b) // R2
      enable_reg && !event_ |=> enable_reg)
      else $error("enable cleared without reset or event");
   chk_badfeed_flag: assert property (@(posedge sys_clk) disable iff (!rst_b) // R3
      badFeed |=> status_reg[gt_pkg::ST_BADFEED_BIT] && !enable_reg)
      else $error("bad feed not reported");
   chk_reset_flag: assert property (@(posedge sys_clk) disable iff (!rst_b) // R4
      sysResetReq |-> rstFlag_reg)
      else $error("reset flag missing after watchdog reset");
   chk_prescale_four: assert property (@(posedge sys_clk) disable iff (!rst_b) // R5
      preTick |-> preCnt_reg == 2'h3 && srcTick)
      else $error("prescaled tick not every fourth source tick");
   chk_count_down: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6
      preTick && count_reg != 24'h000000 && !feedOk && !badFeed |=> count_reg == $past(count_reg) - 24'h000001)
      else $error("counter did not decrement by one");
   chk_min_load: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
      feedOk && enable_reg |=> count_reg >= 24'h0000ff)
      else $error("counter loaded below floor");
   chk_tick_source: assert property (@(posedge sys_clk) disable iff (!rst_b) // R9
      !clkSelExt_reg && srcTick |-> divCnt_reg == 5'h13)
      else $error("derived tick not at divide-by-twenty");
   chk_irq_mode: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
      event_ && !resetMode_reg |=> !sysResetReq)
      else $error("interrupt mode raised a system reset");
   chk_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_b)
      avReq.read && avWaitRequest |=> !avWaitRequest)
      else $error("bus answer later than one wait cycle");
   chk_reset_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
      sysResetReq |=> !sysResetReq)
      else $error("reset request longer than one cycle");
   chk_status_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1
      status_reg[gt_pkg::ST_TIMEOUT_BIT] && !(wrAcc && avReq.address == gt_pkg::STATUS_OFS && wrBits[0])
      |=> status_reg[gt_pkg::ST_TIMEOUT_BIT])
      else $error("timeout status lost without a clear");
   chk_flag_hold: assert property (@(posedge sys_clk) disable iff (!porRst_b) // R4
      rstFlag_reg && !(wrAcc && avReq.address == gt_pkg::RSTFLAG_OFS && wrBits[0]) |=> rstFlag_reg)
      else $error("reset flag lost without a clear");
   chk_feed_reload: assert property (@(posedge sys_clk) disable iff (!rst_b) // R1 R7
      feedOk && enable_reg && reload_reg >= 24'h0000ff |=> count_reg == $past(reload_reg))
      else $error("good feed did not reload the counter");
   chk_enable_floor: assert property (@(posedge sys_clk) disable iff (!rst_b) // R7
      enableSet && !enable_reg |=> count_reg >= 24'h0000ff)
      else $error("enable loaded counter below floor");
   chk_tick_period: assert property (@(posedge sys_clk) disable iff (!rst_b) // R9
      intTick |-> ##20 intTick)
      else $error("derived tick period is not twenty cycles");
   chk_interval_end: assert property (@(posedge sys_clk) disable iff (!rst_b) // R8
      fire |-> ticksSinceLoad_reg == loadedVal_reg)
      else $error("timeout before the loaded interval ran out");
   chk_interval_full: assert property (@(posedge sys_clk) disable iff (!rst_b) // R6 R8
      preTick && ticksSinceLoad_reg == loadedVal_reg |-> fire)
      else $error("no timeout when the loaded interval ran out");
   chk_bus_one_wait: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (avReq.read || avReq.write) && !avWaitRequest |=> avWaitRequest || !(avReq.read || avReq.write))
      else $error("bus answered twice for one request");

   cov_timeout: cover property (@(posedge sys_clk) disable iff (!rst_b) fire && resetMode_reg);
   cov_good_feed: cover property (@(posedge sys_clk) disable iff (!rst_b) feedOk && enable_reg);
   cov_bad_feed: cover property (@(posedge sys_clk) disable iff (!rst_b) badFeed);
   cov_irq: cover property (@(posedge sys_clk) disable iff (!rst_b) irq && !resetMode_reg);
   cov_irq_timeout: cover property (@(posedge sys_clk) disable iff (!rst_b) fire && !resetMode_reg);

endmodule // gt_guard_timer

// [tb/gt_guard_timer_test.sv]
// self-checking register-level bench for the guard timer
`timescale 1ns/100ps
module gt_guard_timer_test;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic porRst_b = 1'b0;
   gt_pkg::gt_av_req_t avReq = '0;
   logic [31:0] avReadData;
   logic avWaitRequest;
   logic extClk = 1'b0;
   logic extRun = 1'b1;
   logic [2:0] extDiv = 3'h0;
   logic sysResetReq;
   logic irq;
   logic [31:0] q;
   int errors = 0;
   int compares = 0;
   int pulses = 0;

   gt_guard_timer gt_guard_timer_i (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .porRst_b(porRst_b),
      .avReq(avReq),
      .avReadData(avReadData),
      .avWaitRequest(avWaitRequest),
      .extClk(extClk),
      .sysResetReq(sysResetReq),
      .irq(irq)
   );

   always #12.5 sys_clk = ~sys_clk;

   // external tick of 8 bus cycles; frozen while the derived source is under test
   always @(posedge sys_clk) begin
      extDiv <= extDiv + 3'h1;
      if (extRun) begin
         extClk <= extDiv[2];
      end
      if (sysResetReq === 1'b1) begin
         pulses <= pulses + 1;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one Avalon cycle; an idle edge follows so the next call never re-drives in the same step
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avReq.read <= ~w;
      avReq.write <= w;
      avReq.address <= a;
      avReq.writedata <= d;
      avReq.byteenable <= 4'hf;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avWaitRequest !== 1'b0 && n < 16);
      q = avReadData;
      if (n >= 16) begin
         errors++;
      end
      avReq.read <= 1'b0;
      avReq.write <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask

   task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   // reload lands on 0xfe or 0xff depending on tick phase
   task automatic chk_near_floor;
      acc(1'b0, gt_pkg::COUNT_OFS, 32'h0);
      chk({31'h0, q >= 32'hfe && q <= 32'hff}, 32'h1);
   endtask

   task automatic wait_fire(input int lo, input int hi, input logic onIrq);
      int n;
      n = 0;
      while ((onIrq ? irq : sysResetReq) !== 1'b1 && n < hi) begin
         @(posedge sys_clk);
         n++;
      end
      chk({31'h0, n >= lo && n < hi}, 32'h1);
      @(posedge sys_clk);
   endtask

   task automatic conclude;
      if (errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      #(25 * 70000);
      errors++;
      conclude();
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      porRst_b <= 1'b1;
      @(posedge sys_clk);
      rdc(gt_pkg::CTRL_OFS, 32'h2);
      rdc(gt_pkg::RELOAD_OFS, 32'hffffff);
      rdc(gt_pkg::COUNT_OFS, 32'hffffff);
      rdc(gt_pkg::STATUS_OFS, 32'h0);
      rdc(gt_pkg::MASK_OFS, 32'h0);
      rdc(gt_pkg::RSTFLAG_OFS, 32'h0);
      wr(gt_pkg::FEED_OFS, 32'h12);
      rdc(gt_pkg::STATUS_OFS, 32'h0);
      wr(gt_pkg::RELOAD_OFS, 32'h10);
      wr(gt_pkg::CLKSEL_OFS, 32'h1);
      wr(gt_pkg::CTRL_OFS, 32'h3);
      chk_near_floor();
      wr(gt_pkg::CTRL_OFS, 32'h2);
      rdc(gt_pkg::CTRL_OFS, 32'h3);
      repeat (4000) @(posedge sys_clk);
      wr(gt_pkg::FEED_OFS, 32'haa);
      wr(gt_pkg::FEED_OFS, 32'h55);
      chk_near_floor();
      // 256 x 4 external ticks of 8 cycles after the feed
      wait_fire(8130, 8220, 1'b0);
      chk(pulses, 1);
      rdc(gt_pkg::STATUS_OFS, 32'h1);
      rdc(gt_pkg::CTRL_OFS, 32'h2);
      rdc(gt_pkg::RSTFLAG_OFS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rdc(gt_pkg::RSTFLAG_OFS, 32'h1);
      porRst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      porRst_b <= 1'b1;
      @(posedge sys_clk);
      rdc(gt_pkg::RSTFLAG_OFS, 32'h0);
      extRun <= 1'b0;
      wr(gt_pkg::RELOAD_OFS, 32'h10);
      wr(gt_pkg::CLKSEL_OFS, 32'h0);
      wr(gt_pkg::CTRL_OFS, 32'h3);
      // derived tick is one per 20 bus cycles
      wait_fire(20360, 20520, 1'b0);
      chk(pulses, 2);
      wr(gt_pkg::RSTFLAG_OFS, 32'h1);
      rdc(gt_pkg::RSTFLAG_OFS, 32'h0);
      wr(gt_pkg::STATUS_OFS, 32'h3);
      wr(gt_pkg::MASK_OFS, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wr(gt_pkg::CTRL_OFS, 32'h1);
      wr(gt_pkg::FEED_OFS, 32'haa);
      wr(gt_pkg::MASK_OFS, 32'h3);
      chk({31'h0, irq}, 32'h1);
      rdc(gt_pkg::STATUS_OFS, 32'h2);
      rdc(gt_pkg::CTRL_OFS, 32'h0);
      chk(pulses, 2);
      rdc(gt_pkg::RSTFLAG_OFS, 32'h0);
      wr(gt_pkg::STATUS_OFS, 32'h3);
      chk({31'h0, irq}, 32'h0);
      wr(gt_pkg::CTRL_OFS, 32'h1);
      wr(gt_pkg::FEED_OFS, 32'h12);
      rdc(gt_pkg::STATUS_OFS, 32'h2);
      wr(gt_pkg::MASK_OFS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(gt_pkg::MASK_OFS, 32'h2);
      chk({31'h0, irq}, 32'h1);
      wr(gt_pkg::STATUS_OFS, 32'h2);
      chk({31'h0, irq}, 32'h0);
      // timeout in interrupt mode: status and irq only, no reset request
      wr(gt_pkg::MASK_OFS, 32'h1);
      wr(gt_pkg::CTRL_OFS, 32'h1);
      wait_fire(20360, 20520, 1'b1);
      chk(pulses, 2);
      rdc(gt_pkg::STATUS_OFS, 32'h1);
      rdc(gt_pkg::CTRL_OFS, 32'h0);
      rdc(gt_pkg::RSTFLAG_OFS, 32'h0);
      conclude();
   end
endmodule // gt_guard_timer_test
